// file: core/pc_stack_regs.vh
`ifndef PC_STACK_REGS_VH
`define PC_STACK_REGS_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_PWR_STAT 12'h08E
`define IDX_PC_LOW 12'h002
`define IDX_STATUS 12'h003
`define IDX_FILE_PTR 12'h004
`define IDX_PC_LATCH 12'h00A
`define IDX_PCVIEW 12'h0F0

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define PWR_POR_BIT 1
`define PWR_BOR_BIT 0
`define STATUS_BANK_BIT 7
`define LATCH_PAGE_BIT 3
`define LATCH_TOP_BIT 4
`define PC_W 13
`define TGT_W 11
`define SP_W 3
`define STACK_DEPTH 8

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define PC_RESET 13'h0000
`define PC_INT_VECTOR 13'h0004
`define PC_ONE 13'h0001
`define BYTE_ZERO 8'h00
`define INDIRECT_ADDR 8'h00
`define SP_ONE 3'h1
`define SYNC_W 2
`define SYNC_BOR 0
`define SYNC_FUSE 1

`endif

// file: core/pc_stack_indirect_unit.v
// Overview of operation
// RULE1 - Power-on flag bit 1, cleared at power-on
// RULE2 - Brown-out flag bit 0, cleared on brown-out
// RULE3 - Fuse set: flag 1 at power-on
// RULE4 - Fuse clear: power-on flag value undefined
// RULE5 - Bits 7 to 2 read zero
// RULE6 - 13-bit counter, low byte read/write
// RULE7 - Upper bits only loaded from latch
// RULE8 - Low byte write loads upper five bits
// RULE9 - Jump target 11 bits plus latch page
// RULE10 - Call saves full counter, return restores
// RULE11 - Eight by 13 stack, hidden pointer
// RULE12 - Push on call/interrupt, pop on returns
// RULE13 - Stack operations leave latch unchanged
// RULE14 - Stack wraps circularly, no overflow flag
// RULE15 - Indirect port redirects to pointer target
// RULE16 - Self-pointed indirect read returns zero
// RULE17 - Self-pointed indirect write stores nothing
// RULE18 - Address is bank bit plus pointer
// RULE19 - Software bumps latch on table rollover
// RULE20 - Counter increments per fetch otherwise
`timescale 1ns/1ps
`include "pc_stack_regs.vh"

module pc_stack_indirect_unit (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Reset-generation pins
  input wire brownout_evt,
  input wire brownout_enable_fuse,
  // Execution core program flow
  input wire core_fetch,
  input wire core_goto,
  input wire core_call,
  input wire core_int,
  input wire core_ret,
  input wire [10:0] core_target,
  output reg [12:0] pc_out,
  // Execution core register-file access
  input wire core_file_rd,
  input wire core_file_wr,
  input wire [7:0] core_file_addr,
  input wire [7:0] core_file_wdata,
  output reg [7:0] file_rdata,
  output reg file_rdata_valid,
  // Register-file RAM
  output reg [8:0] ram_addr,
  output reg ram_rd,
  output reg ram_wr,
  output reg [7:0] ram_wdata,
  input wire [7:0] ram_rdata
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [1:0] pin_in;
  reg [1:0] sync1_r;
  reg [1:0] sync2_r;
  reg [1:0] sync3_r;
  reg [1:0] pin_st_r;
  assign pin_in[`SYNC_BOR] = brownout_evt;
  assign pin_in[`SYNC_FUSE] = brownout_enable_fuse;

  // A change counts only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_W; gi = gi + 1)
    begin : g_sync
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          pin_st_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi])
          begin
            pin_st_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  wire bor_level = pin_st_r[`SYNC_BOR];
  wire fuse_on = pin_st_r[`SYNC_FUSE];
  wire bor_agree = (sync2_r[`SYNC_BOR] == sync3_r[`SYNC_BOR]);
  wire bor_rise = bor_agree & sync3_r[`SYNC_BOR] & ~bor_level;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire [11:0] idx = paddr[13:2];
  wire word_ok = (paddr[1:0] == 2'b00) & (paddr[31:14] == 18'h00000);
  wire acc = psel & penable & ~pready;
  wire take = psel & penable & pready;
  wire hit_pwr = word_ok & (idx == `IDX_PWR_STAT);
  wire hit_lo = word_ok & (idx == `IDX_PC_LOW);
  wire hit_stat = word_ok & (idx == `IDX_STATUS);
  wire hit_ptr = word_ok & (idx == `IDX_FILE_PTR);
  wire hit_lath = word_ok & (idx == `IDX_PC_LATCH);
  wire hit_view = word_ok & (idx == `IDX_PCVIEW);
  wire mapped = hit_pwr | hit_lo | hit_stat | hit_ptr | hit_lath | hit_view;
  // Writes land only at the edge that completes the access phase
  wire wr_take = take & pwrite & mapped & ~pslverr;

  // ----------------------------------------
  // Software-visible registers
  // ----------------------------------------
  reg por_flag_r;
  reg bor_flag_r;
  reg bank_r;
  reg [7:0] file_ptr_r;
  reg [4:0] lath_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // presetn stands for the power-on reset of the core
      por_flag_r <= 1'b0; // RULE1
      // Fuse state is not known under reset; 1 suits both fuse cases
      bor_flag_r <= 1'b1; // RULE3 RULE4
      bank_r <= 1'b0;
      file_ptr_r <= `BYTE_ZERO;
      lath_r <= 5'h00;
    end
    else
    begin
      if (wr_take & hit_pwr)
      begin
        por_flag_r <= pwdata[`PWR_POR_BIT]; // RULE1
      end
      // Brown-out event beats a same-cycle software set
      if (fuse_on & bor_rise)
      begin
        bor_flag_r <= 1'b0; // RULE2 RULE3
      end
      else if (wr_take & hit_pwr)
      begin
        bor_flag_r <= pwdata[`PWR_BOR_BIT]; // RULE2
      end
      // Bank bit is kept so the indirect address is complete; direct accesses ignore it
      if (wr_take & hit_stat)
      begin
        bank_r <= pwdata[`STATUS_BANK_BIT];
      end
      if (wr_take & hit_ptr)
      begin
        file_ptr_r <= pwdata[7:0];
      end
      // Latch is written only by software, never by the stack
      if (wr_take & hit_lath)
      begin
        lath_r <= pwdata[4:0]; // RULE13
      end
    end
  end

  // ----------------------------------------
  // APB response
  // ----------------------------------------
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h00000000;
    if (hit_pwr)
    begin
      rd_mux = {30'h00000000, por_flag_r, bor_flag_r}; // RULE5
    end
    else if (hit_lo)
    begin
      rd_mux = {24'h000000, pc_out[7:0]}; // RULE6
    end
    else if (hit_stat)
    begin
      rd_mux = {24'h000000, bank_r, 7'h00};
    end
    else if (hit_ptr)
    begin
      rd_mux = {24'h000000, file_ptr_r};
    end
    else if (hit_lath)
    begin
      rd_mux = {27'h0000000, lath_r};
    end
    else if (hit_view)
    begin
      // Pin view shows the filtered levels, not the raw pins
      rd_mux = {28'h0000000, fuse_on, bor_level, 2'b00};
    end
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= acc;
      if (acc)
      begin
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Program counter and return stack
  // ----------------------------------------
  reg [12:0] stack_mem [0:7];
  reg [2:0] sp_r;
  wire lo_wr = wr_take & hit_lo;
  wire [2:0] sp_dec = sp_r - `SP_ONE;
  // A low-byte write overrides any same-cycle stack request
  wire do_push = ~lo_wr & (core_call | core_int); // RULE12
  wire do_pop = ~lo_wr & ~do_push & core_ret; // RULE12

  reg [12:0] pc_nxt;
  always @*
  begin
    pc_nxt = pc_out;
    if (lo_wr)
    begin
      pc_nxt = {lath_r, pwdata[7:0]}; // RULE7 RULE8
    end
    else if (core_int)
    begin
      pc_nxt = `PC_INT_VECTOR;
    end
    else if (core_call | core_goto)
    begin
      pc_nxt = {lath_r[`LATCH_TOP_BIT], lath_r[`LATCH_PAGE_BIT], core_target}; // RULE9
    end
    else if (core_ret)
    begin
      pc_nxt = stack_mem[sp_dec]; // RULE10
    end
    else if (core_fetch)
    begin
      pc_nxt = pc_out + `PC_ONE; // RULE20
    end
  end

  // Stack entries carry no reset; a pop before any push is undefined
  always @(posedge pclk)
  begin
    if (do_push)
    begin
      stack_mem[sp_r] <= pc_out; // RULE10 RULE11
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_out <= `PC_RESET;
      sp_r <= 3'h0;
    end
    else
    begin
      pc_out <= pc_nxt;
      // Pointer wraps modulo eight and has no overflow indication
      if (do_push)
      begin
        sp_r <= sp_r + `SP_ONE; // RULE11 RULE14
      end
      else if (do_pop)
      begin
        sp_r <= sp_dec; // RULE14
      end
    end
  end

  // ----------------------------------------
  // Register-file access and indirect port
  // ----------------------------------------
  wire via_port = (core_file_addr == `INDIRECT_ADDR);
  wire self_ptr = via_port & (file_ptr_r == `INDIRECT_ADDR);
  // Self-pointed accesses never reach the RAM, so no stray write can land
  wire [8:0] eff_addr = via_port ? {bank_r, file_ptr_r} : {1'b0, core_file_addr}; // RULE15 RULE18
  reg rd_pend_r;
  reg rd_zero_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ram_addr <= 9'h000;
      ram_rd <= 1'b0;
      ram_wr <= 1'b0;
      ram_wdata <= `BYTE_ZERO;
      rd_pend_r <= 1'b0;
      rd_zero_r <= 1'b0;
      file_rdata <= `BYTE_ZERO;
      file_rdata_valid <= 1'b0;
    end
    else
    begin
      ram_addr <= eff_addr;
      ram_rd <= core_file_rd & ~self_ptr;
      // Self-pointed write becomes a no-operation
      ram_wr <= core_file_wr & ~core_file_rd & ~self_ptr; // RULE17
      ram_wdata <= core_file_wdata;
      rd_pend_r <= core_file_rd;
      rd_zero_r <= self_ptr;
      file_rdata_valid <= rd_pend_r;
      // Read data is taken while the RAM still drives it
      if (rd_pend_r)
      begin
        file_rdata <= rd_zero_r ? `BYTE_ZERO : ram_rdata; // RULE16
      end
    end
  end

endmodule // pc_stack_indirect_unit

// file: sim/pc_stack_indirect_unit_properties.sv
`timescale 1ns/1ps
module unit_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // Program flow
  input wire core_fetch,
  input wire core_goto,
  input wire core_call,
  input wire core_int,
  input wire core_ret,
  input wire [10:0] core_target,
  input wire [12:0] pc_out,
  // Register file
  input wire [7:0] file_rdata,
  input wire file_rdata_valid,
  input wire [8:0] ram_addr,
  input wire ram_rd,
  input wire ram_wr,
  input wire [7:0] ram_rdata
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire jump = core_goto | core_call | core_int | core_ret;
  // Return only counts when nothing of higher priority shares its cycle
  wire lone_ret = core_ret & ~core_goto & ~core_call & ~core_int;
  a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("wait state count wrong");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_fetch_incr: assert property (core_fetch && !jump && !psel |=>
    pc_out == $past(pc_out) + 13'h0001) else $error("fetch did not advance");
  a_jump_target: assert property ((core_goto || core_call) && !core_int && !psel |=>
    pc_out[10:0] == $past(core_target)) else $error("jump target lost");
  a_int_vector: assert property (core_int && !psel |=> pc_out == 13'h0004)
    else $error("interrupt vector wrong");
  a_call_return: assert property (core_call && !core_int && !psel ##1 !jump && !psel
    ##1 lone_ret && !psel |=> pc_out == $past(pc_out, 3)) else $error("return address wrong");
  a_low_load: assert property (psel && penable && pready && pwrite && paddr == 32'h8
    |=> pc_out[7:0] == $past(pwdata[7:0])) else $error("low byte not loaded");
  a_no_self: assert property ((ram_rd || ram_wr) |-> ram_addr[7:0] != 8'h00)
    else $error("access through port to itself");
  a_read_return: assert property (ram_rd |=> file_rdata_valid &&
    file_rdata == $past(ram_rdata)) else $error("read data not returned");
endmodule // unit_props

bind pc_stack_indirect_unit unit_props unit_props_inst (.*);

// file: sim/ram_model.sv
`timescale 1ns/1ps
module ram_model (
  // Register-file RAM
  input wire pclk,
  input wire [8:0] ram_addr,
  input wire ram_rd,
  input wire ram_wr,
  input wire [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [512];
  logic [7:0] last = 8'h00;
  // Each cell starts as its own low address byte, so reads are predictable
  initial foreach (mem[i]) mem[i] = i[7:0];
  always @(posedge pclk) if (ram_wr) mem[ram_addr] <= ram_wdata;
  always @(posedge pclk) if (ram_rd) last <= mem[ram_addr];
  // Not selected: show the inverse of the last value, never a held copy
  assign ram_rdata = ram_rd ? mem[ram_addr] : ~last;
endmodule // ram_model

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [11:0] idx_pwr = 12'h08E, idx_lo = 12'h002, idx_st = 12'h003;
  localparam logic [11:0] idx_ptr = 12'h004, idx_lat = 12'h00A;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdat, t;
  logic pready, pslverr, file_rdata_valid, ram_rd, ram_wr;
  logic brownout_evt = '0, brownout_enable_fuse = '1, core_fetch = '0, core_goto = '0;
  logic core_call = '0, core_int = '0, core_ret = '0, core_file_rd = '0, core_file_wr = '0;
  logic [10:0] core_target = '0;
  logic [12:0] pc_out, p;
  logic [12:0] pushed [10];
  logic [7:0] core_file_addr = '0, core_file_wdata = '0, file_rdata, ram_wdata, ram_rdata;
  logic [8:0] ram_addr;
  int fails = 0, cmp_count = 0;
  pc_stack_indirect_unit pc_stack_indirect_unit_inst (.*);
  ram_model ram_model_inst (.*);
  initial forever #50 pclk = ~pclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Error flag is folded into bit 31 so one compare covers both
  task apb(input logic w, input logic [11:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {18'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata | {pslverr, 31'h0};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(rdat, {24'h0, e});
  endtask
  task fl(input logic [4:0] f, input logic [10:0] tg);
    @(posedge pclk);
    {core_fetch, core_goto, core_call, core_int, core_ret} <= f;
    core_target <= tg;
    @(posedge pclk);
    {core_fetch, core_goto, core_call, core_int, core_ret} <= 5'h00;
    @(negedge pclk);
  endtask
  task fa(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    core_file_rd <= !w;
    core_file_wr <= w;
    core_file_addr <= a;
    core_file_wdata <= d;
    @(posedge pclk);
    core_file_rd <= 1'b0;
    core_file_wr <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  task bo;
    brownout_evt <= 1'b1;
    repeat (3) @(posedge pclk);
    brownout_evt <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task give_verdict;
    $display("checks=%0d fails=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fails++;
    give_verdict;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(32));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(idx_pwr, 8'h01);
    apb(1'b1, idx_pwr, 8'hFF);
    rd(idx_pwr, 8'h03);
    bo();
    rd(idx_pwr, 8'h02);
    apb(1'b1, idx_pwr, 8'h03);
    brownout_enable_fuse <= 1'b0;
    repeat (8) @(posedge pclk);
    bo();
    rd(idx_pwr, 8'h03);
    apb(1'b0, 12'h07F, 8'h00);
    chk(rdat, 32'h80000000);
    apb(1'b1, idx_lat, 8'h15);
    apb(1'b1, idx_lo, 8'h34);
    @(negedge pclk);
    chk(pc_out, 13'h1534);
    rd(idx_lo, 8'h34);
    t = $urandom;
    fl(5'h08, t[10:0]);
    chk(pc_out, {2'h2, t[10:0]});
    p = pc_out;
    apb(1'b1, idx_lat, 8'h0A);
    @(negedge pclk);
    chk(pc_out, p);
    fl(5'h10, 11'h000);
    chk(pc_out, p + 13'h0001);
    for (int i = 0; i < 10; i++)
    begin
      t = $urandom;
      pushed[i] = pc_out;
      fl(5'h04, t[10:0]);
      chk(pc_out, {2'h1, t[10:0]});
    end
    for (int i = 0; i < 8; i++)
    begin
      fl(5'h01, 11'h000);
      chk(pc_out, pushed[9 - i]);
    end
    fl(5'h01, 11'h000);
    chk(pc_out, pushed[9]);
    rd(idx_lat, 8'h0A);
    p = pc_out;
    fl(5'h02, 11'h000);
    chk(pc_out, 13'h0004);
    fl(5'h01, 11'h000);
    chk(pc_out, p);
    apb(1'b1, idx_lat, 8'h0B);
    apb(1'b1, idx_lo, 8'h00);
    @(negedge pclk);
    chk(pc_out, 13'h0B00);
    apb(1'b1, idx_ptr, 8'h05);
    fa(1'b0, 8'h00, 8'h00);
    chk(file_rdata, 8'h05);
    fa(1'b1, 8'h00, 8'hA5);
    fa(1'b0, 8'h05, 8'h00);
    chk(file_rdata, 8'hA5);
    apb(1'b1, idx_st, 8'h80);
    fa(1'b0, 8'h00, 8'h00);
    chk(file_rdata, 8'h05);
    apb(1'b1, idx_ptr, 8'h00);
    fa(1'b1, 8'h00, 8'h77);
    fa(1'b0, 8'h00, 8'h00);
    chk(file_rdata, 8'h00);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(idx_pwr, 8'h01);
    give_verdict;
  end
endmodule // testbench
